// ==== logic/asp_regs.vh ====
`ifndef ASP_REGS_VH
`define ASP_REGS_VH

// serial port register offsets
`define ASP_ADDR_REF_PWR      16'h00A1
`define ASP_ADDR_FBDIV_PWR    16'h00A2
`define ASP_ADDR_INT_RSVD0    16'h0200
`define ASP_ADDR_INT_STAT     16'h0201
`define ASP_ADDR_INT_RSVD2    16'h0202
`define ASP_ADDR_INT_RSVD3    16'h0203
`define ASP_ADDR_GLB_RSVD13   16'h0213
`define ASP_ADDR_BOOT_FAIL    16'h0214
`define ASP_ADDR_BOOT_STAT    16'h0215

// field positions
`define ASP_REF_OFF_BIT       4
`define ASP_FRAC_DIS_BIT      1
`define ASP_LOL_BIT           2
`define ASP_SIGLOSS_BIT       0
`define ASP_BOOT_FAIL_BIT     0
`define ASP_CRC_GOOD_BIT      3
`define ASP_LOAD_DONE_BIT     0

// reset values
`define ASP_RST_REF_OFF       1'b0
`define ASP_RST_FRAC_DIS      1'b0
`define ASP_RST_STICKY        1'b0
`define ASP_RST_BOOT_FAIL     1'b0
`define ASP_RST_CRC_GOOD      1'b1
`define ASP_RST_LOAD_DONE     1'b0

// serial slave address, value is arbitrary
`define ASP_DEV_ADDR          7'h5A

`endif

// ==== logic/asp_sync.v ====
`timescale 1ns/1ps
`default_nettype none

module asp_sync #(
   parameter         W       = 4,
   // per-bit reset level, set to the idle level of each pin
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   // clock and reset
   input  wire         clk_i,
   input  wire         rst_b_i,
   // asynchronous inputs and their synchronised copies
   input  wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);

   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         reg meta_r;
         reg sync_r;
         always @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               meta_r <= RST_VAL[g];
               sync_r <= RST_VAL[g];
            end else begin
               meta_r <= d_i[g];
               sync_r <= meta_r;
            end
         end
         assign q_o[g] = sync_r;
      end
   endgenerate

endmodule

`default_nettype wire

// ==== logic/asp_status_regs.v ====
// Contract
// - ref-output power-down bit at one turns off regulator, resets zero.
// - feedback divider is fractional at zero, integer at one, resets 0.
// - each monitored alarm sets its own interrupt status bit.
// - a set status bit stays set after its alarm goes away.
// - a status bit clears only on reset or when a one is written to it serially.
// - the alarm output pins follow the live alarm state, no latching.
// - bit 2 of register 0201 is the sticky lock-loss flag, reset zero.
// - bit 0 of register 0201 is the sticky signal-loss flag, reset zero.
// - read-only boot-failure flag sets on a failed read, reset clears.
// - bit 3 of 0215 is an active-low CRC flag; at zero the port locks.
// - bit 0 of 0215 sets when the EEPROM read completes, reset clears.
`timescale 1ns/1ps
`default_nettype none
`include "asp_regs.vh"

module asp_status_regs #(
   parameter [6:0] DEV_ADDR = `ASP_DEV_ADDR
) (
   // clock and reset (reset is the hardware reset pin)
   input  wire mclk_i,
   input  wire rst_b_i,
   // serial port, sda is open drain
   input  wire scl_i,
   input  wire sda_i,
   output reg  sda_o,
   output reg  sda_oe_b_o,
   // live alarms from the analog side
   input  wire lock_loss_i,
   input  wire signal_loss_i,
   // eeprom loader status, same clock
   input  wire eeprom_load_done_i,
   input  wire eeprom_read_fail_i,
   input  wire eeprom_crc_fail_i,
   // alarm pins
   output reg  lock_loss_pin_o,
   output reg  signal_loss_pin_o,
   // power controls
   output reg  ref_power_down_o,
   output reg  fractional_feedback_disable_o,
   // status flags
   output reg  lock_loss_sticky_flag_o,
   output reg  signal_loss_sticky_flag_o,
   output reg  boot_read_failed_flag_o,
   output reg  eeprom_checksum_good_o,
   output reg  eeprom_load_complete_o,
   output reg  serial_port_locked_o
);

   localparam [2:0] ST_IDLE  = 3'd0;
   localparam [2:0] ST_RX    = 3'd1;
   localparam [2:0] ST_ACK   = 3'd2;
   localparam [2:0] ST_TX    = 3'd3;
   localparam [2:0] ST_TXACK = 3'd4;

   localparam [1:0] IDX_DEV  = 2'd0;
   localparam [1:0] IDX_AHI  = 2'd1;
   localparam [1:0] IDX_ALO  = 2'd2;
   localparam [1:0] IDX_DATA = 2'd3;

   function hit;
      input [15:0] a;
      input [15:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   // synchronised pins
   wire [3:0] sync_q;
   wire       scl_s;
   wire       sda_s;
   wire       lol_s;
   wire       sgl_s;

   // bus pins idle high, so their flops reset high: no false edge
   asp_sync #(
      .W       (4),
      .RST_VAL (4'hC)
   ) u_sync (
      .clk_i   (mclk_i),
      .rst_b_i (rst_b_i),
      .d_i     ({scl_i, sda_i, lock_loss_i, signal_loss_i}),
      .q_o     (sync_q)
   );

   assign scl_s = sync_q[3];
   assign sda_s = sync_q[2];
   assign lol_s = sync_q[1];
   assign sgl_s = sync_q[0];

   reg        scl_d_r;
   reg        sda_d_r;
   reg [2:0]  state_r;
   reg [3:0]  bit_cnt_r;
   reg [7:0]  shift_r;
   reg [1:0]  byte_idx_r;
   reg        rnw_r;
   reg [15:0] addr_r;
   reg        wr_en_r;
   reg [15:0] wr_addr_r;
   reg [7:0]  wr_data_r;
   reg [7:0]  rd_byte;

   wire scl_rise = scl_s & ~scl_d_r;
   wire scl_fall = ~scl_s & scl_d_r;
   wire start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
   wire stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;

   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   // read mux, reserved and unmapped bits read zero
   always @* begin
      rd_byte = 8'h00;
      if (hit(addr_r, `ASP_ADDR_REF_PWR)) begin
         rd_byte[`ASP_REF_OFF_BIT] = ref_power_down_o;
      end else if (hit(addr_r, `ASP_ADDR_FBDIV_PWR)) begin
         rd_byte[`ASP_FRAC_DIS_BIT] = fractional_feedback_disable_o;
      end else if (hit(addr_r, `ASP_ADDR_INT_STAT)) begin
         rd_byte[`ASP_LOL_BIT] = lock_loss_sticky_flag_o;
         rd_byte[`ASP_SIGLOSS_BIT] = signal_loss_sticky_flag_o;
      end else if (hit(addr_r, `ASP_ADDR_BOOT_FAIL)) begin
         rd_byte[`ASP_BOOT_FAIL_BIT] = boot_read_failed_flag_o;
      end else if (hit(addr_r, `ASP_ADDR_BOOT_STAT)) begin
         rd_byte[`ASP_CRC_GOOD_BIT]  = eeprom_checksum_good_o;
         rd_byte[`ASP_LOAD_DONE_BIT] = eeprom_load_complete_o;
      end
   end

   // serial slave: device byte, two address bytes, then data with
   // auto-increment; no clock stretching
   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_r    <= ST_IDLE;
         bit_cnt_r  <= 4'h0;
         shift_r    <= 8'h00;
         byte_idx_r <= IDX_DEV;
         rnw_r      <= 1'b0;
         addr_r     <= 16'h0000;
         wr_en_r    <= 1'b0;
         wr_addr_r  <= 16'h0000;
         wr_data_r  <= 8'h00;
         sda_o      <= 1'b0;
         sda_oe_b_o <= 1'b1;
      end else begin
         wr_en_r <= 1'b0;
         sda_o   <= 1'b0;
         if (start_c) begin
            state_r    <= ST_RX;
            bit_cnt_r  <= 4'h0;
            byte_idx_r <= IDX_DEV;
            sda_oe_b_o <= 1'b1;
         end else if (stop_c) begin
            state_r    <= ST_IDLE;
            sda_oe_b_o <= 1'b1;
         end else begin
            case (state_r)
               ST_IDLE: begin
                  sda_oe_b_o <= 1'b1;
               end
               ST_RX: begin
                  if (scl_rise && bit_cnt_r != 4'd8) begin
                     shift_r   <= {shift_r[6:0], sda_s};
                     bit_cnt_r <= bit_cnt_r + 4'd1;
                  end else if (scl_fall && bit_cnt_r == 4'd8) begin
                     bit_cnt_r <= 4'h0;
                     case (byte_idx_r)
                        IDX_DEV: begin
                           // locked port: address never acknowledged
                           if (shift_r[7:1] == DEV_ADDR &&
                               eeprom_checksum_good_o) begin
                              rnw_r      <= shift_r[0];
                              sda_oe_b_o <= 1'b0;
                              state_r    <= ST_ACK;
                           end else begin
                              state_r <= ST_IDLE;
                           end
                        end
                        IDX_AHI: begin
                           addr_r[15:8] <= shift_r;
                           sda_oe_b_o   <= 1'b0;
                           state_r      <= ST_ACK;
                        end
                        IDX_ALO: begin
                           addr_r[7:0] <= shift_r;
                           sda_oe_b_o  <= 1'b0;
                           state_r     <= ST_ACK;
                        end
                        IDX_DATA: begin
                           wr_en_r    <= 1'b1;
                           wr_addr_r  <= addr_r;
                           wr_data_r  <= shift_r;
                           sda_oe_b_o <= 1'b0;
                           state_r    <= ST_ACK;
                        end
                        default: begin
                           state_r <= ST_IDLE;
                        end
                     endcase
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     if (byte_idx_r == IDX_DATA) begin
                        addr_r <= addr_r + 16'h0001;
                     end else begin
                        byte_idx_r <= byte_idx_r + 2'd1;
                     end
                     if (byte_idx_r == IDX_DEV && rnw_r) begin
                        shift_r    <= rd_byte;
                        sda_oe_b_o <= rd_byte[7];
                        bit_cnt_r  <= 4'd1;
                        state_r    <= ST_TX;
                     end else begin
                        sda_oe_b_o <= 1'b1;
                        state_r    <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (bit_cnt_r == 4'd8) begin
                        sda_oe_b_o <= 1'b1;
                        addr_r     <= addr_r + 16'h0001;
                        state_r    <= ST_TXACK;
                     end else begin
                        shift_r    <= {shift_r[6:0], 1'b0};
                        sda_oe_b_o <= shift_r[6];
                        bit_cnt_r  <= bit_cnt_r + 4'd1;
                     end
                  end
               end
               ST_TXACK: begin
                  if (scl_rise && sda_s) begin
                     state_r <= ST_IDLE;
                  end else if (scl_fall) begin
                     shift_r    <= rd_byte;
                     sda_oe_b_o <= rd_byte[7];
                     bit_cnt_r  <= 4'd1;
                     state_r    <= ST_TX;
                  end
               end
               default: begin
                  state_r    <= ST_IDLE;
                  sda_oe_b_o <= 1'b1;
               end
            endcase
         end
      end
   end

   wire wr_ref   = wr_en_r & hit(wr_addr_r, `ASP_ADDR_REF_PWR);
   wire wr_fbdiv = wr_en_r & hit(wr_addr_r, `ASP_ADDR_FBDIV_PWR);
   wire wr_stat  = wr_en_r & hit(wr_addr_r, `ASP_ADDR_INT_STAT);
   wire clr_lol  = wr_stat & wr_data_r[`ASP_LOL_BIT];
   wire clr_sgl  = wr_stat & wr_data_r[`ASP_SIGLOSS_BIT];

   // sticky next values: set wins over a same-cycle clear
   wire lol_nxt = lol_s | (lock_loss_sticky_flag_o & ~clr_lol);
   wire sgl_nxt = sgl_s | (signal_loss_sticky_flag_o & ~clr_sgl);

   always @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ref_power_down_o              <= `ASP_RST_REF_OFF;
         fractional_feedback_disable_o <= `ASP_RST_FRAC_DIS;
         lock_loss_sticky_flag_o       <= `ASP_RST_STICKY;
         signal_loss_sticky_flag_o     <= `ASP_RST_STICKY;
         boot_read_failed_flag_o       <= `ASP_RST_BOOT_FAIL;
         eeprom_checksum_good_o        <= `ASP_RST_CRC_GOOD;
         eeprom_load_complete_o        <= `ASP_RST_LOAD_DONE;
         serial_port_locked_o          <= 1'b0;
         lock_loss_pin_o               <= 1'b0;
         signal_loss_pin_o             <= 1'b0;
      end else begin
         if (wr_ref) begin
            ref_power_down_o <= wr_data_r[`ASP_REF_OFF_BIT];
         end
         if (wr_fbdiv) begin
            fractional_feedback_disable_o <=
               wr_data_r[`ASP_FRAC_DIS_BIT];
         end
         lock_loss_sticky_flag_o   <= lol_nxt;
         signal_loss_sticky_flag_o <= sgl_nxt;
         lock_loss_pin_o   <= lol_s;
         signal_loss_pin_o <= sgl_s;
         boot_read_failed_flag_o <= boot_read_failed_flag_o |
                                    eeprom_read_fail_i;
         eeprom_checksum_good_o  <= eeprom_checksum_good_o &
                                    ~eeprom_crc_fail_i;
         serial_port_locked_o    <= ~(eeprom_checksum_good_o &
                                      ~eeprom_crc_fail_i);
         eeprom_load_complete_o  <= eeprom_load_complete_o |
                                    eeprom_load_done_i;
      end
   end

endmodule

`default_nettype wire

// ==== test/asp_status_regs_properties.sv ====
`timescale 1ns/1ps
`default_nettype none

module asp_status_regs_properties (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // serial port
   input wire logic scl_i,
   input wire logic sda_oe_b_o,
   // alarms
   input wire logic lock_loss_i,
   input wire logic signal_loss_i,
   input wire logic lock_loss_pin_o,
   input wire logic signal_loss_pin_o,
   input wire logic lock_loss_sticky_flag_o,
   input wire logic signal_loss_sticky_flag_o,
   // eeprom status
   input wire logic eeprom_load_done_i,
   input wire logic eeprom_read_fail_i,
   input wire logic eeprom_crc_fail_i,
   input wire logic boot_read_failed_flag_o,
   input wire logic eeprom_checksum_good_o,
   input wire logic eeprom_load_complete_o,
   input wire logic serial_port_locked_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_b_i);

   // alarm held long enough to cross the sync and output flops
   sequence s_ll_steady;
      $stable(lock_loss_i) [*4];
   endsequence
   sequence s_ls_steady;
      $stable(signal_loss_i) [*4];
   endsequence

   ll_pin_live_a: assert property (
      s_ll_steady |-> lock_loss_pin_o == lock_loss_i)
      else $error("lock loss pin not live");
   ls_pin_live_a: assert property (
      s_ls_steady |-> signal_loss_pin_o == signal_loss_i)
      else $error("signal loss pin not live");
   ll_sticky_set_a: assert property (
      lock_loss_pin_o |-> lock_loss_sticky_flag_o)
      else $error("lock loss sticky not set");
   ls_sticky_set_a: assert property (
      signal_loss_pin_o |-> signal_loss_sticky_flag_o)
      else $error("signal loss sticky not set");
   ll_clear_only_a: assert property (
      $fell(lock_loss_sticky_flag_o) |-> !lock_loss_pin_o && !scl_i)
      else $error("lock loss sticky cleared wrongly");
   done_sets_a: assert property (
      eeprom_load_done_i |-> ##[1:2] eeprom_load_complete_o)
      else $error("load complete not set");
   done_holds_a: assert property (
      $past(eeprom_load_complete_o) |-> eeprom_load_complete_o)
      else $error("load complete dropped");
   fail_sets_a: assert property (
      eeprom_read_fail_i |-> ##[1:2] boot_read_failed_flag_o)
      else $error("boot failure not set");
   fail_holds_a: assert property (
      boot_read_failed_flag_o |=> boot_read_failed_flag_o)
      else $error("boot failure dropped");
   crc_locks_a: assert property (
      eeprom_crc_fail_i |->
         ##[1:2] (serial_port_locked_o && !eeprom_checksum_good_o))
      else $error("checksum failure does not lock");
   locked_silent_a: assert property (
      serial_port_locked_o |-> sda_oe_b_o)
      else $error("locked port drives sda");
endmodule

bind asp_status_regs asp_status_regs_properties
   u_asp_status_regs_properties (.*);

`default_nettype wire

// ==== test/asp_status_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "asp_regs.vh"

module asp_status_regs_tb;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic scl = 1'b1;
   logic m_sda = 1'b1;
   logic ll = 1'b0, ls = 1'b0, ld = 1'b0, rf = 1'b0, cf = 1'b0;
   wire  sda_o, sda_oe_b_o, ll_pin, ls_pin, ref_pd, frac_dis;
   wire  ll_st, ls_st, boot_f, crc_ok, done, locked;
   // open-drain wire with pull-up
   wire  sda_w = m_sda & (sda_oe_b_o | sda_o);
   int   fails = 0;
   int   n_checks = 0;

   asp_status_regs u_asp_status_regs (
      .mclk_i(mclk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe_b_o(sda_oe_b_o),
      .lock_loss_i(ll), .signal_loss_i(ls),
      .eeprom_load_done_i(ld), .eeprom_read_fail_i(rf),
      .eeprom_crc_fail_i(cf),
      .lock_loss_pin_o(ll_pin), .signal_loss_pin_o(ls_pin),
      .ref_power_down_o(ref_pd), .fractional_feedback_disable_o(frac_dis),
      .lock_loss_sticky_flag_o(ll_st), .signal_loss_sticky_flag_o(ls_st),
      .boot_read_failed_flag_o(boot_f), .eeprom_checksum_good_o(crc_ok),
      .eeprom_load_complete_o(done), .serial_port_locked_o(locked));

   initial begin
      forever #5 mclk_i = ~mclk_i;
   end

   task cyc(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask

   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task bo(input logic b);
      m_sda = b;
      cyc(10);
      scl = 1'b1;
      cyc(10);
      scl = 1'b0;
   endtask

   task bi(output logic b);
      m_sda = 1'b1;
      cyc(10);
      scl = 1'b1;
      cyc(10);
      b = sda_w;
      scl = 1'b0;
   endtask

   // byte out, k returns one when the slave acknowledged
   task by(input logic [7:0] d, output logic k);
      for (int i = 7; i >= 0; i--) bo(d[i]);
      bi(k);
      k = ~k;
   endtask

   task st;
      m_sda = 1'b1;
      cyc(10);
      scl = 1'b1;
      cyc(10);
      m_sda = 1'b0;
      cyc(10);
      scl = 1'b0;
   endtask

   task sp;
      m_sda = 1'b0;
      cyc(10);
      scl = 1'b1;
      cyc(10);
      m_sda = 1'b1;
      cyc(10);
   endtask

   task wr(input logic [15:0] a, input logic [7:0] d, input logic ek);
      logic k;
      st;
      by({`ASP_DEV_ADDR, 1'b0}, k);
      chk(k, ek);
      by(a[15:8], k);
      by(a[7:0], k);
      by(d, k);
      sp;
   endtask

   task rd(input logic [15:0] a, input logic [7:0] e);
      logic       k;
      logic [7:0] d;
      st;
      by({`ASP_DEV_ADDR, 1'b0}, k);
      by(a[15:8], k);
      by(a[7:0], k);
      st;
      by({`ASP_DEV_ADDR, 1'b1}, k);
      for (int i = 7; i >= 0; i--) bi(d[i]);
      bo(1'b1);
      sp;
      chk(d, e);
   endtask

   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // tests take about 18000 cycles; allow roughly twice that
   initial begin
      #400000;
      fails++;
      tally_and_finish;
   end

   initial begin
      cyc(8);
      rst_b_i = 1'b1;
      cyc(3);
      chk(ref_pd, 1'b0);
      chk(frac_dis, 1'b0);
      rd(`ASP_ADDR_INT_STAT, 8'h00);
      rd(`ASP_ADDR_BOOT_STAT, 8'h08);
      $display("test reset values done");
      wr(`ASP_ADDR_REF_PWR, 8'h10, 1'b1);
      chk(ref_pd, 1'b1);
      rd(`ASP_ADDR_REF_PWR, 8'h10);
      wr(`ASP_ADDR_FBDIV_PWR, 8'h02, 1'b1);
      chk(frac_dis, 1'b1);
      wr(`ASP_ADDR_REF_PWR, 8'h00, 1'b1);
      chk(ref_pd, 1'b0);
      wr(`ASP_ADDR_GLB_RSVD13, 8'h00, 1'b1);
      chk(frac_dis, 1'b1);
      $display("test power controls done");
      ll = 1'b1;
      cyc(5);
      chk(ll_pin, 1'b1);
      chk(ll_st, 1'b1);
      ll = 1'b0;
      cyc(5);
      chk(ll_pin, 1'b0);
      chk(ll_st, 1'b1);
      ls = 1'b1;
      cyc(5);
      ls = 1'b0;
      cyc(5);
      rd(`ASP_ADDR_INT_STAT, 8'h05);
      wr(`ASP_ADDR_INT_STAT, 8'h00, 1'b1);
      rd(`ASP_ADDR_INT_STAT, 8'h05);
      wr(`ASP_ADDR_INT_STAT, 8'h04, 1'b1);
      rd(`ASP_ADDR_INT_STAT, 8'h01);
      ls = 1'b1;
      cyc(5);
      wr(`ASP_ADDR_INT_STAT, 8'h01, 1'b1);
      chk(ls_st, 1'b1);
      ls = 1'b0;
      cyc(5);
      wr(`ASP_ADDR_INT_STAT, 8'h01, 1'b1);
      chk(ls_st, 1'b0);
      $display("test sticky alarms done");
      ld = 1'b1;
      cyc(1);
      ld = 1'b0;
      rf = 1'b1;
      cyc(1);
      rf = 1'b0;
      cyc(3);
      rd(`ASP_ADDR_BOOT_STAT, 8'h09);
      rd(`ASP_ADDR_BOOT_FAIL, 8'h01);
      wr(`ASP_ADDR_BOOT_STAT, 8'h00, 1'b1);
      rd(`ASP_ADDR_BOOT_STAT, 8'h09);
      cf = 1'b1;
      cyc(1);
      cf = 1'b0;
      cyc(3);
      chk(crc_ok, 1'b0);
      chk(locked, 1'b1);
      wr(`ASP_ADDR_REF_PWR, 8'h10, 1'b0);
      chk(ref_pd, 1'b0);
      rst_b_i = 1'b0;
      cyc(2);
      rst_b_i = 1'b1;
      cyc(3);
      chk(crc_ok, 1'b1);
      chk(boot_f, 1'b0);
      chk(done, 1'b0);
      chk(frac_dis, 1'b0);
      wr(`ASP_ADDR_REF_PWR, 8'h10, 1'b1);
      chk(ref_pd, 1'b1);
      $display("test eeprom status done");
      tally_and_finish;
   end
endmodule

`default_nettype wire
